// ===== core/tcc_pkg.sv
package tcc_pkg;
  localparam int          CNT_W      = 16;
  localparam int          BYTE_W     = 8;
  localparam int          MODE_W     = 4;
  localparam int          ACT_W      = 2;
  localparam int          SEL_W      = 3;
  localparam int          NUM_CH     = 2;
  localparam int          PRESC_W    = 10;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] COUNT_BOT  = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [7:0]  TEMP_RST   = 8'h00;
  localparam logic        OC_RST     = 1'b0;
  localparam int          CH_A       = 0;
  localparam int          CH_B       = 1;

  typedef enum logic [3:0] {
    TCC_MODE_NORMAL   = 4'b0000,
    TCC_MODE_CTC_A    = 4'b0100,
    TCC_MODE_CTC_CAP  = 4'b1100,
    TCC_MODE_RSVD     = 4'b1101,
    TCC_MODE_FPWM_CAP = 4'b1110,
    TCC_MODE_FPWM_A   = 4'b1111
  } tcc_mode_e;

  typedef enum logic [1:0] {
    TCC_ACT_NONE   = 2'b00,
    TCC_ACT_TOGGLE = 2'b01,
    TCC_ACT_CLEAR  = 2'b10,
    TCC_ACT_SET    = 2'b11
  } tcc_act_e;

  localparam logic [2:0]  SEL_STOP   = 3'h0;
  localparam logic [2:0]  SEL_DIV1   = 3'h1;
  localparam logic [2:0]  SEL_DIV8   = 3'h2;
  localparam logic [2:0]  SEL_DIV64  = 3'h3;
  localparam logic [2:0]  SEL_DIV256 = 3'h4;
  localparam logic [2:0]  SEL_DIV1K  = 3'h5;
  localparam logic [9:0]  DIV1_LAST   = 10'h000;
  localparam logic [9:0]  DIV8_LAST   = 10'h007;
  localparam logic [9:0]  DIV64_LAST  = 10'h03F;
  localparam logic [9:0]  DIV256_LAST = 10'h0FF;
  localparam logic [9:0]  DIV1K_LAST  = 10'h3FF;
endpackage : tcc_pkg

// ===== core/tcc_chan_if.sv
`timescale 1ns/1ps
interface tcc_chan_if;
  logic       match_evt;
  logic       force_evt;
  logic [1:0] action;
  logic       state;

  modport ctrl (
    output match_evt,
    output force_evt,
    output action,
    input  state
  );
  modport chan (
    input  match_evt,
    input  force_evt,
    input  action,
    output state
  );
endinterface : tcc_chan_if

// ===== core/tcc_prescaler.sv
`timescale 1ns/1ps
module tcc_prescaler #(
  parameter int PRESC_W = tcc_pkg::PRESC_W
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_i,
  input  wire logic [tcc_pkg::SEL_W-1:0] clock_select_i,
  output logic                           tick_o
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic [2:0] sel;
    logic       tick;
  } tcc_psc_s;

  tcc_psc_s st_r;
  tcc_psc_s st_nxt;
  logic [9:0] last;
  logic       run;

  if (PRESC_W < 10) begin : g_chk
    $error("tcc_prescaler: PRESC_W must cover the 1024 divider");
  end

  always_comb begin
    st_nxt = st_r;
    run    = 1'b1;
    unique case (clock_select_i)
      SEL_DIV1:   last = DIV1_LAST;
      SEL_DIV8:   last = DIV8_LAST;
      SEL_DIV64:  last = DIV64_LAST;
      SEL_DIV256: last = DIV256_LAST;
      SEL_DIV1K:  last = DIV1K_LAST;
      default: begin
        last = DIV1_LAST;
        run  = 1'b0;
      end
    endcase
    st_nxt.sel  = clock_select_i;
    st_nxt.tick = 1'b0;
    // Restart on a new divider so the first period is whole
    if (!run || clock_select_i != st_r.sel) begin
      st_nxt.cnt = 10'h000;
    end else if (st_r.cnt == last) begin
      st_nxt.cnt  = 10'h000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

  a_tick_single : assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (clock_select_i == SEL_DIV8 && st_r.tick && $stable(clock_select_i))
      |-> ##1 !st_r.tick)
    else $error("Divide-by-8 tick lasted more than one cycle");
endmodule : tcc_prescaler

// ===== core/tcc_compare_channel.sv
`timescale 1ns/1ps
module tcc_compare_channel (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  tcc_chan_if.chan  ch
);
  import tcc_pkg::*;

  typedef struct packed {
    logic oc;
  } tcc_ch_s;

  tcc_ch_s  st_r;
  tcc_ch_s  st_nxt;
  tcc_act_e act;

  always_comb begin
    st_nxt = st_r;
    act    = tcc_act_e'(ch.action);
    // Forced and real events take the same path
    if (ch.match_evt || ch.force_evt) begin
      unique case (act)
        TCC_ACT_NONE:   st_nxt.oc = st_r.oc;
        TCC_ACT_TOGGLE: st_nxt.oc = ~st_r.oc;
        TCC_ACT_CLEAR:  st_nxt.oc = 1'b0;
        TCC_ACT_SET:    st_nxt.oc = 1'b1;
      endcase
    end
  end

  // No mode input: the state outlives mode changes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r.oc <= OC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ch.state = st_r.oc;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // Own disable, since the default one would mask every attempt
  a_reset_clears : assert property (@(posedge sys_clk_i) disable iff (1'b0)
    reset_i |=> !st_r.oc)
    else $error("Output state not zero after reset");
  a_toggle_event : assert property ((ch.force_evt || ch.match_evt)
    && ch.action == TCC_ACT_TOGGLE |=> st_r.oc != $past(st_r.oc))
    else $error("Toggle event did not invert output state");
  a_none_holds : assert property (ch.action == TCC_ACT_NONE |=> $stable(st_r.oc))
    else $error("Output state moved with action zero");
  a_set_clear : assert property ((ch.match_evt || ch.force_evt) && ch.action[1]
    |=> st_r.oc == $past(ch.action[0]))
    else $error("Set or clear action gave wrong state");
endmodule : tcc_compare_channel

// ===== core/tcc_timer_top.sv
`timescale 1ns/1ps
module tcc_timer_top (
  input  wire logic                        sys_clk_i,
  input  wire logic                        reset_i,
  input  wire logic [tcc_pkg::SEL_W-1:0]   clock_select_i,
  input  wire logic [tcc_pkg::MODE_W-1:0]  waveform_mode_select_i,
  input  wire logic [tcc_pkg::ACT_W-1:0]   compare_output_action_a_i,
  input  wire logic [tcc_pkg::ACT_W-1:0]   compare_output_action_b_i,
  input  wire logic [tcc_pkg::NUM_CH-1:0]  force_strobe_i,
  input  wire logic                        count_wr_i,
  input  wire logic [tcc_pkg::CNT_W-1:0]   count_wdata_i,
  input  wire logic [tcc_pkg::NUM_CH-1:0]  compare_high_wr_i,
  input  wire logic [tcc_pkg::NUM_CH-1:0]  compare_low_wr_i,
  input  wire logic                        capture_high_wr_i,
  input  wire logic                        capture_low_wr_i,
  input  wire logic [tcc_pkg::BYTE_W-1:0]  write_byte_i,
  input  wire logic [tcc_pkg::NUM_CH-1:0]  compare_match_flag_clr_i,
  input  wire logic                        overflow_flag_clr_i,
  input  wire logic                        capture_flag_clr_i,
  input  wire logic [tcc_pkg::NUM_CH-1:0]  port_data_i,
  input  wire logic [tcc_pkg::NUM_CH-1:0]  compare_pin_direction_i,
  output logic [tcc_pkg::CNT_W-1:0]        timer_count_o,
  output logic [tcc_pkg::CNT_W-1:0]        compare_value_a_o,
  output logic [tcc_pkg::CNT_W-1:0]        compare_value_b_o,
  output logic [tcc_pkg::CNT_W-1:0]        capture_top_value_o,
  output logic [tcc_pkg::NUM_CH-1:0]       compare_match_flag_o,
  output logic                             overflow_flag_o,
  output logic                             capture_flag_o,
  output logic [tcc_pkg::NUM_CH-1:0]       compare_output_state_o,
  output logic [tcc_pkg::NUM_CH-1:0]       pin_out_o,
  output logic [tcc_pkg::NUM_CH-1:0]       pin_oe_n_o
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]         count;
    logic [NUM_CH-1:0][15:0]  cmp;
    logic [CNT_W-1:0]         cap;
    logic [BYTE_W-1:0]        temp;
    logic                     block;
    logic [NUM_CH-1:0]        cmf;
    logic                     ovf;
    logic                     capf;
    logic [NUM_CH-1:0]        oc;
    logic [NUM_CH-1:0]        pin;
    logic [NUM_CH-1:0]        pin_oe_n;
  } tcc_top_s;

  tcc_top_s                 st_r;
  tcc_top_s                 st_nxt;
  tcc_mode_e                mode;
  logic                     tick;
  logic                     non_pwm;
  logic                     top_is_cap;
  logic                     clr_on_top;
  logic [CNT_W-1:0]         top_val;
  logic                     top_hit;
  logic                     wrap;
  logic [NUM_CH-1:0]        hit;
  logic [NUM_CH-1:0]        ch_state;
  logic [NUM_CH-1:0][1:0]   action;

  tcc_chan_if ch_if [NUM_CH] ();

  tcc_prescaler #(
    .PRESC_W (PRESC_W)
  ) u_presc (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .clock_select_i (clock_select_i),
    .tick_o         (tick)
  );

  assign action[CH_A] = compare_output_action_a_i;
  assign action[CH_B] = compare_output_action_b_i;

  always_comb begin
    mode       = tcc_mode_e'(waveform_mode_select_i);
    non_pwm    = (mode == TCC_MODE_NORMAL) || (mode == TCC_MODE_CTC_A)
              || (mode == TCC_MODE_CTC_CAP) || (mode == TCC_MODE_RSVD);
    top_is_cap = (mode == TCC_MODE_CTC_CAP) || (mode == TCC_MODE_FPWM_CAP);
    // Sequence depends on mode only, never on action bits
    clr_on_top = (mode == TCC_MODE_CTC_A) || (mode == TCC_MODE_CTC_CAP)
              || (mode == TCC_MODE_FPWM_CAP) || (mode == TCC_MODE_FPWM_A);
    // TOP is read live, no shadow copy
    top_val    = top_is_cap ? st_r.cap : st_r.cmp[CH_A];
    // Block from a counter write eats the TOP equality too
    top_hit    = tick && !st_r.block && clr_on_top && (st_r.count == top_val);
    wrap       = tick && !top_hit && (st_r.count == COUNT_MAX);
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign hit[i] = tick && !st_r.block && (st_r.count == st_r.cmp[i]);
    assign ch_if[i].match_evt = hit[i];
    // Strobe is a pulse, never stored, dead in PWM modes
    assign ch_if[i].force_evt = force_strobe_i[i] && non_pwm;
    assign ch_if[i].action    = action[i];
    assign ch_state[i]        = ch_if[i].state;

    tcc_compare_channel u_ch (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .ch        (ch_if[i])
    );
  end

  always_comb begin
    st_nxt = st_r;

    if (count_wr_i) begin
      st_nxt.count = count_wdata_i;
      // Held until a tick, so a stopped timer still blocks
      st_nxt.block = 1'b1;
    end else if (tick) begin
      st_nxt.block = 1'b0;
      if (top_hit) begin
        st_nxt.count = COUNT_BOT;
      end else begin
        // Past TOP the count runs to MAX and wraps
        st_nxt.count = st_r.count + 16'h0001;
      end
    end

    // Set beats clear on every flag
    for (int i = 0; i < NUM_CH; i++) begin
      st_nxt.cmf[i] = hit[i] || (st_r.cmf[i] && !compare_match_flag_clr_i[i]);
    end
    st_nxt.ovf  = (wrap && !count_wr_i)
               || (st_r.ovf && !overflow_flag_clr_i);
    // Action bits have no path into the capture flag
    st_nxt.capf = (top_hit && top_is_cap)
               || (st_r.capf && !capture_flag_clr_i);

    if (capture_high_wr_i || compare_high_wr_i != '0) begin
      st_nxt.temp = write_byte_i;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (compare_low_wr_i[i]) begin
        st_nxt.cmp[i] = {st_r.temp, write_byte_i};
      end
    end
    // Capture register only writable while it defines TOP
    if (capture_low_wr_i && top_is_cap) begin
      st_nxt.cap = {st_r.temp, write_byte_i};
    end

    st_nxt.oc = ch_state;
    for (int i = 0; i < NUM_CH; i++) begin
      st_nxt.pin[i]      = (action[i] != 2'b00) ? ch_state[i] : port_data_i[i];
      st_nxt.pin_oe_n[i] = !compare_pin_direction_i[i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r          <= '0;
      st_r.count    <= COUNT_RST;
      st_r.temp     <= TEMP_RST;
      st_r.pin_oe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timer_count_o          = st_r.count;
  assign compare_value_a_o      = st_r.cmp[CH_A];
  assign compare_value_b_o      = st_r.cmp[CH_B];
  assign capture_top_value_o    = st_r.cap;
  assign compare_match_flag_o   = st_r.cmf;
  assign overflow_flag_o        = st_r.ovf;
  assign capture_flag_o         = st_r.capf;
  assign compare_output_state_o = st_r.oc;
  assign pin_out_o              = st_r.pin;
  assign pin_oe_n_o             = st_r.pin_oe_n;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_write_then_tick;
    count_wr_i ##1 (!count_wr_i && tick);
  endsequence

  sequence s_ctc_top_tick;
    tick && !st_r.block && !count_wr_i && mode == TCC_MODE_CTC_A
      && st_r.count == st_r.cmp[CH_A];
  endsequence

  a_write_blocks : assert property (s_write_then_tick |=> !$rose(st_r.cmf[CH_A])
    && !$rose(st_r.cmf[CH_B]))
    else $error("Match flag set on tick after counter write");
  a_ctc_clear : assert property (s_ctc_top_tick |=> st_r.count == COUNT_BOT
    && st_r.cmf[CH_A])
    else $error("Clear-on-match did not clear counter and flag A");
  a_normal_inc : assert property (tick && !count_wr_i && mode == TCC_MODE_NORMAL
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Normal mode did not increment");
  a_ovf_wrap : assert property (tick && !count_wr_i && !top_hit
    && st_r.count == COUNT_MAX |=> st_r.ovf && st_r.count == COUNT_BOT)
    else $error("Overflow flag missing at wrap to zero");
  a_force_no_flag : assert property ($rose(st_r.cmf[CH_A]) |-> $past(hit[CH_A]))
    else $error("Match flag set without a real match");
  a_set_wins : assert property (hit[CH_B] && compare_match_flag_clr_i[CH_B]
    |=> st_r.cmf[CH_B])
    else $error("Clear beat a coincident match");
  a_pin_override : assert property (compare_output_action_a_i != 2'b00
    |=> pin_out_o[CH_A] == $past(ch_state[CH_A]))
    else $error("Pin not driven from output state");
  a_stage_copy : assert property (compare_low_wr_i[CH_A] && !compare_high_wr_i[CH_A]
    |=> compare_value_a_o[15:8] == $past(st_r.temp))
    else $error("High byte not copied from staging byte");
  a_cap_flag_top : assert property (tick && !st_r.block && !count_wr_i
    && mode == TCC_MODE_CTC_CAP && st_r.count == st_r.cap |=> capture_flag_o)
    else $error("Capture flag not set at TOP");
  // Written TOP plus one, so a TOP of MAX wraps without a false alarm
  a_top_lost : assert property (count_wr_i && clr_on_top && count_wdata_i == top_val
    ##1 (tick && !count_wr_i) |=> st_r.count == $past(count_wdata_i, 2) + 16'h0001)
    else $error("TOP match not lost after counter write");
endmodule : tcc_timer_top

// ===== dv/tcc_cpu_model.sv
`timescale 1ns/1ps
module tcc_cpu_model (
  input  wire logic        sys_clk_i,
  output logic [1:0]       cmp_hi_wr_o,
  output logic [1:0]       cmp_lo_wr_o,
  output logic             cap_hi_wr_o,
  output logic             cap_lo_wr_o,
  output logic             cnt_wr_o,
  output logic [15:0]      cnt_data_o,
  output logic [7:0]       byte_o
);
  initial begin
    cmp_hi_wr_o = 2'h0;
    cmp_lo_wr_o = 2'h0;
    cap_hi_wr_o = 1'b0;
    cap_lo_wr_o = 1'b0;
    cnt_wr_o    = 1'b0;
    cnt_data_o  = 16'h5AA5;
    byte_o      = 8'hA5;
  end

  // Shared staging byte, so high and low go back to back
  task automatic wr16(input int sel, input logic [15:0] val);
    @(posedge sys_clk_i);
    if (sel == 2) cap_hi_wr_o <= 1'b1;
    else cmp_hi_wr_o[sel[0]] <= 1'b1;
    byte_o <= val[15:8];
    @(posedge sys_clk_i);
    cmp_hi_wr_o <= 2'h0;
    cap_hi_wr_o <= 1'b0;
    if (sel == 2) cap_lo_wr_o <= 1'b1;
    else cmp_lo_wr_o[sel[0]] <= 1'b1;
    byte_o <= val[7:0];
    @(posedge sys_clk_i);
    cmp_lo_wr_o <= 2'h0;
    cap_lo_wr_o <= 1'b0;
    byte_o <= ~val[7:0];
  endtask : wr16

  // Inverted data afterwards exposes a late sample
  task automatic wr_count(input logic [15:0] val);
    @(posedge sys_clk_i);
    cnt_wr_o   <= 1'b1;
    cnt_data_o <= val;
    @(posedge sys_clk_i);
    cnt_wr_o   <= 1'b0;
    cnt_data_o <= ~val;
  endtask : wr_count
endmodule : tcc_cpu_model

// ===== dv/tcc_timer_top_test.sv
`timescale 1ns/1ps
module tcc_timer_top_test;
  import tcc_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic [2:0]  sel = 3'h0;
  logic [3:0]  mode = 4'h0;
  logic [1:0]  act_a = 2'h0;
  logic [1:0]  act_b = 2'h0;
  logic [1:0]  frc = 2'h0;
  logic [1:0]  mclr = 2'h0;
  logic        oclr = 1'b0;
  logic        cclr = 1'b0;
  logic [1:0]  pdat = 2'h0;
  logic [1:0]  dir = 2'h0;
  logic [1:0]  chw, clw, mflag, ostate, pout, poe_n;
  logic        khw, klw, cwr, ovf, capf;
  logic [15:0] cdat, cnt, cva, cvb, ctop;
  logic [7:0]  wbyte;
  int          n_fail = 0;
  int          check_count = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  tcc_cpu_model tcc_cpu_model_inst (.sys_clk_i(sys_clk_i), .cmp_hi_wr_o(chw),
    .cmp_lo_wr_o(clw), .cap_hi_wr_o(khw), .cap_lo_wr_o(klw), .cnt_wr_o(cwr),
    .cnt_data_o(cdat), .byte_o(wbyte));

  tcc_timer_top tcc_timer_top_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clock_select_i(sel), .waveform_mode_select_i(mode),
    .compare_output_action_a_i(act_a), .compare_output_action_b_i(act_b),
    .force_strobe_i(frc), .count_wr_i(cwr), .count_wdata_i(cdat),
    .compare_high_wr_i(chw), .compare_low_wr_i(clw), .capture_high_wr_i(khw),
    .capture_low_wr_i(klw), .write_byte_i(wbyte), .compare_match_flag_clr_i(mclr),
    .overflow_flag_clr_i(oclr), .capture_flag_clr_i(cclr), .port_data_i(pdat),
    .compare_pin_direction_i(dir), .timer_count_o(cnt), .compare_value_a_o(cva),
    .compare_value_b_o(cvb), .capture_top_value_o(ctop), .compare_match_flag_o(mflag),
    .overflow_flag_o(ovf), .capture_flag_o(capf), .compare_output_state_o(ostate),
    .pin_out_o(pout), .pin_oe_n_o(poe_n));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc

  task automatic clr_flags();
    @(posedge sys_clk_i);
    mclr <= 2'h3;
    oclr <= 1'b1;
    cclr <= 1'b1;
    @(posedge sys_clk_i);
    mclr <= 2'h0;
    oclr <= 1'b0;
    cclr <= 1'b0;
  endtask : clr_flags

  // Bounded poll; which 0 is match flag A, 1 is overflow, 2 is capture flag
  task automatic wait_for(input int which);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge sys_clk_i);
      if ((which == 0 && mflag[0] === 1'b1) || (which == 1 && ovf === 1'b1)) return;
      if (which == 2 && capf === 1'b1) return;
    end
    chk("wait timeout", 16'h0001, 16'h0000);
  endtask : wait_for

  task automatic t_reset();
    @(negedge sys_clk_i);
    chk("count", cnt, COUNT_RST);
    chk("state", {14'h0, ostate}, 16'h0000);
    chk("flags", {13'h0, mflag, ovf}, 16'h0000);
    chk("oe_n", {14'h0, poe_n}, 16'h0003);
    $display("test reset done");
  endtask : t_reset

  task automatic t_force();
    logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic       exps [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      act_a <= acts[i];
      frc   <= 2'h1;
      @(posedge sys_clk_i);
      frc   <= 2'h0;
      cyc(2);
      @(negedge sys_clk_i);
      chk("forced state", {15'h0, ostate[0]}, {15'h0, exps[i]});
      chk("forced flag", {15'h0, mflag[0]}, 16'h0000);
      chk("forced count", cnt, 16'h0000);
    end
    @(posedge sys_clk_i);
    mode  <= 4'hF;
    act_a <= 2'h1;
    frc   <= 2'h1;
    @(posedge sys_clk_i);
    frc   <= 2'h0;
    cyc(3);
    @(negedge sys_clk_i);
    chk("pwm force", {15'h0, ostate[0]}, 16'h0001);
    @(posedge sys_clk_i);
    mode <= 4'h0;
    cyc(3);
    @(negedge sys_clk_i);
    chk("mode change", {15'h0, ostate[0]}, 16'h0001);
    $display("test force done");
  endtask : t_force

  task automatic t_pin();
    @(posedge sys_clk_i);
    // State was preset by forcing before the pin turns to output
    dir   <= 2'h1;
    pdat  <= 2'h2;
    act_a <= 2'h1;
    cyc(3);
    @(negedge sys_clk_i);
    chk("pin out", {14'h0, pout}, 16'h0003);
    chk("pin oe_n", {14'h0, poe_n}, 16'h0002);
    @(posedge sys_clk_i);
    act_a <= 2'h0;
    cyc(3);
    @(negedge sys_clk_i);
    chk("port value", {14'h0, pout}, 16'h0002);
    $display("test pin done");
  endtask : t_pin

  // Clear-on-match A, so the blocked equality is also the TOP
  task automatic t_block();
    @(posedge sys_clk_i);
    mode <= 4'h4;
    tcc_cpu_model_inst.wr16(0, 16'h0010);
    @(negedge sys_clk_i);
    chk("cmp a", cva, 16'h0010);
    tcc_cpu_model_inst.wr_count(16'h0010);
    clr_flags();
    sel <= SEL_DIV1;
    cyc(8);
    @(negedge sys_clk_i);
    chk("blocked flag", {15'h0, mflag[0]}, 16'h0000);
    chk("stopped write", cnt, 16'h0016);
    tcc_cpu_model_inst.wr_count(16'h0010);
    cyc(4);
    @(negedge sys_clk_i);
    chk("running write", cnt, 16'h0014);
    chk("running flag", {15'h0, mflag[0]}, 16'h0000);
    @(posedge sys_clk_i);
    sel <= SEL_STOP;
    cyc(3);
    $display("test block done");
  endtask : t_block

  task automatic t_ctc();
    int   n;
    logic prev;
    mode  <= 4'h4;
    act_a <= 2'h1;
    tcc_cpu_model_inst.wr16(0, 16'h0005);
    tcc_cpu_model_inst.wr_count(16'h0000);
    clr_flags();
    sel <= SEL_DIV1;
    wait_for(0);
    chk("ctc clear", cnt, 16'h0000);
    @(posedge sys_clk_i);
    mclr <= 2'h1;
    @(posedge sys_clk_i);
    mclr <= 2'h0;
    cyc(1);
    @(negedge sys_clk_i);
    chk("flag cleared", {15'h0, mflag[0]}, 16'h0000);
    // Sync to one change, then count cycles to the next
    prev = ostate[0];
    n = 0;
    while (n < 100 && ostate[0] === prev) begin
      @(negedge sys_clk_i);
      n++;
    end
    prev = ostate[0];
    n = 0;
    while (n < 100) begin
      @(negedge sys_clk_i);
      n++;
      if (ostate[0] !== prev) break;
    end
    chk("half period", n[15:0], 16'h0006);
    @(posedge sys_clk_i);
    act_a <= 2'h3;
    cyc(8);
    @(negedge sys_clk_i);
    chk("new action", {15'h0, ostate[0]}, 16'h0001);
    @(posedge sys_clk_i);
    sel <= SEL_STOP;
    $display("test ctc done");
  endtask : t_ctc

  task automatic t_wrap(input logic [3:0] m, input logic [15:0] start);
    mode <= m;
    cyc(2);
    tcc_cpu_model_inst.wr_count(start);
    tcc_cpu_model_inst.wr16(0, 16'h0002);
    clr_flags();
    sel <= SEL_DIV1;
    wait_for(1);
    chk("wrap count", cnt, COUNT_BOT);
    chk("no early match", {15'h0, mflag[0]}, 16'h0000);
    wait_for(0);
    chk("match count", cnt, (m == 4'h4) ? 16'h0000 : 16'h0003);
    sel <= SEL_STOP;
    cyc(3);
    $display("test wrap done");
  endtask : t_wrap

  // Capture register defines TOP; compare A still matches below it
  task automatic t_cap();
    mode <= 4'hC;
    tcc_cpu_model_inst.wr16(1, 16'h1234);
    tcc_cpu_model_inst.wr16(2, 16'h0003);
    tcc_cpu_model_inst.wr_count(16'h0000);
    clr_flags();
    @(negedge sys_clk_i);
    chk("cmp b", cvb, 16'h1234);
    chk("cap top", ctop, 16'h0003);
    @(posedge sys_clk_i);
    sel <= SEL_DIV1;
    wait_for(2);
    chk("cap clear", cnt, 16'h0000);
    chk("cap mode match a", {15'h0, mflag[0]}, 16'h0001);
    @(posedge sys_clk_i);
    sel <= SEL_STOP;
    cyc(3);
    $display("test cap done");
  endtask : t_cap

  // Divide by 8: first tick after the restart, then one per 8 cycles
  task automatic t_div();
    mode <= 4'h0;
    tcc_cpu_model_inst.wr_count(16'h0000);
    sel <= SEL_DIV8;
    cyc(26);
    @(negedge sys_clk_i);
    chk("div8 count", cnt, 16'h0003);
    @(posedge sys_clk_i);
    sel <= SEL_STOP;
    cyc(3);
    $display("test div done");
  endtask : t_div

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial begin
    cyc(20);
    reset_i <= 1'b0;
    t_reset();
    t_force();
    t_pin();
    t_block();
    t_ctc();
    t_wrap(4'h4, 16'hFFFD);
    t_wrap(4'h0, 16'hFFFE);
    t_cap();
    t_div();
    complete_run();
  end

  initial begin
    cyc(20000);
    n_fail++;
    complete_run();
  end
endmodule : tcc_timer_top_test
